/* File: include/epmux_map.vh */
// Constants for the Ethernet port pin-mode mapping block
`ifndef EPMUX_MAP_VH
`define EPMUX_MAP_VH
`define EPMUX_MODE_MSB 4
`define EPMUX_MODE_LSB 3
`define EPMUX_FE_RMII 2'h3
`define EPMUX_FE_MII 2'h1
`define EPMUX_FE_GPSI 2'h0
`define EPMUX_UP_GMII 2'h3
`define EPMUX_UP_MII 2'h0
`define EPMUX_FM_IDLE 3'h0
`define EPMUX_FM_RMII 3'h1
`define EPMUX_FM_MII 3'h2
`define EPMUX_FM_GPSI 3'h3
`define EPMUX_FM_GMII 3'h4
`define EPMUX_DET_CYCLES 16'h0010
`endif

/* File: hdl/epmux_fe_port.v */
// One access port: mode decode, pin mapping and clock direction
`timescale 1ns/100ps
`include "epmux_map.vh"
module epmux_fe_port (
	input wire i_mclk,
	input wire i_arst_n,
	input wire [7:0] i_access_port_iface_mode_field,
	input wire i_idle,
	input wire [3:0] i_rxd,
	input wire i_access_carrier_valid_in,
	input wire i_col,
	input wire i_access_tx_clock_pin,
	input wire i_access_rx_clock_pin,
	input wire i_clk_drive,
	input wire i_txen,
	input wire [3:0] i_txd,
	output reg [2:0] o_mode,
	output reg [3:0] o_rxd,
	output reg o_rx_valid,
	output reg o_col,
	output reg o_tx_clk_edge,
	output reg o_txen,
	output reg [3:0] o_txd,
	output reg o_clk_oe
);
	reg [1:0] txc_s_reg;
	reg [1:0] rxc_s_reg;
	reg txc_d_reg;
	reg [2:0] mode_next;
	wire [1:0] fld;
	assign fld = i_access_port_iface_mode_field[`EPMUX_MODE_MSB:`EPMUX_MODE_LSB];
	always @* begin
		case (fld)
			`EPMUX_FE_RMII: mode_next = `EPMUX_FM_RMII;
			`EPMUX_FE_MII: mode_next = `EPMUX_FM_MII;
			`EPMUX_FE_GPSI: mode_next = `EPMUX_FM_GPSI;
			default: mode_next = `EPMUX_FM_IDLE;
		endcase
		if (i_idle)
			mode_next = `EPMUX_FM_IDLE;
	end
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			txc_s_reg <= 2'h0;
			rxc_s_reg <= 2'h0;
			txc_d_reg <= 1'b0;
			o_mode <= `EPMUX_FM_IDLE;
			o_rxd <= 4'h0;
			o_rx_valid <= 1'b0;
			o_col <= 1'b0;
			o_tx_clk_edge <= 1'b0;
			o_txen <= 1'b0;
			o_txd <= 4'h0;
			o_clk_oe <= 1'b0;
		end else begin
			// Clocks pass two flops; only the transmit clock then gets edge detection
			txc_s_reg <= {txc_s_reg[0], i_access_tx_clock_pin};
			rxc_s_reg <= {rxc_s_reg[0], i_access_rx_clock_pin};
			txc_d_reg <= txc_s_reg[1];
			o_mode <= mode_next;
			o_tx_clk_edge <= 1'b0;
			o_clk_oe <= 1'b0;
			o_rxd <= 4'h0;
			o_rx_valid <= 1'b0;
			o_col <= 1'b0;
			o_txen <= 1'b0;
			o_txd <= 4'h0; // Transmit pins stay driven, low when idle
			case (o_mode)
				`EPMUX_FM_RMII: begin
					o_rxd <= {2'h0, i_rxd[1:0]};
					o_rx_valid <= i_access_carrier_valid_in;
					o_txen <= i_txen;
					o_txd <= {2'h0, i_txd[1:0]};
				end
				`EPMUX_FM_MII: begin
					o_rxd <= i_rxd;
					o_rx_valid <= i_access_carrier_valid_in;
					o_col <= i_col;
					o_txen <= i_txen;
					o_txd <= i_txd;
					o_clk_oe <= i_clk_drive;
					o_tx_clk_edge <= txc_s_reg[1] & ~txc_d_reg;
				end
				`EPMUX_FM_GPSI: begin
					o_rxd <= {3'h0, i_rxd[0]};
					o_rx_valid <= i_access_carrier_valid_in;
					o_col <= i_col;
					o_txen <= i_txen;
					o_txd <= {3'h0, i_txd[0]};
					o_clk_oe <= i_clk_drive;
					o_tx_clk_edge <= txc_s_reg[1] & ~txc_d_reg;
				end
				default: begin
				end
			endcase
		end
	end
endmodule

/* File: hdl/epmux_top.v */
// Pin-mode mapping for two access ports and the gigabit uplink
`timescale 1ns/100ps
`include "epmux_map.vh"
module epmux_top (
	input wire i_mclk,
	input wire i_arst_n,
	input wire i_module_detect_strap,
	input wire [2:0] i_module_present,
	input wire [7:0] i_access_port_iface_mode_field_0,
	input wire [7:0] i_access_port_iface_mode_field_1,
	input wire [7:0] i_uplink_iface_mode_field,
	input wire [7:0] i_fe_rxd,
	input wire [1:0] i_fe_crs_dv,
	input wire [1:0] i_fe_col,
	input wire [1:0] i_fe_txclk,
	input wire [1:0] i_fe_rxclk,
	input wire [1:0] i_fe_clk_drive,
	input wire [1:0] i_fe_txen,
	input wire [7:0] i_fe_txd,
	input wire [7:0] i_up_rxd,
	input wire i_up_rxdv,
	input wire i_up_rxer,
	input wire i_up_crs,
	input wire i_up_col,
	input wire i_gigabit_reference_clock_in,
	input wire i_uplink_mii_tx_clock_in,
	input wire i_up_txen,
	input wire [7:0] i_up_txd,
	output reg [5:0] o_fe_mode,
	output reg [7:0] o_fe_rxd,
	output reg [1:0] o_fe_rx_valid,
	output reg [1:0] o_fe_col,
	output reg [1:0] o_fe_tx_clk_edge,
	output reg [1:0] o_fe_clk_oe,
	output reg [1:0] o_fe_txen,
	output reg [7:0] o_fe_txd,
	output reg [2:0] o_up_mode,
	output reg [7:0] o_up_rxd,
	output reg o_up_rxdv,
	output reg o_up_rxer,
	output reg o_up_crs,
	output reg o_up_col,
	output reg o_up_tx_clk_edge,
	output reg o_uplink_gigabit_tx_clock_out,
	output reg o_up_txen,
	output reg [7:0] o_up_txd,
	output reg [2:0] o_present
);
	reg [2:0] pres_s1_reg;
	reg [2:0] pres_s2_reg;
	reg [1:0] strap_s_reg;
	reg [1:0] gref_s_reg;
	reg [1:0] mtx_s_reg;
	reg gref_d_reg;
	reg mtx_d_reg;
	reg [2:0] up_mode_next;
	wire [2:0] pres_w;
	wire [2:0] idle;
	wire [5:0] fe_mode_w;
	wire [7:0] fe_rxd_w;
	wire [1:0] fe_rxv_w;
	wire [1:0] fe_col_w;
	wire [1:0] fe_edge_w;
	wire [1:0] fe_oe_w;
	wire [1:0] fe_txen_w;
	wire [7:0] fe_txd_w;
	wire [1:0] up_fld;
	wire [7:0] fe_fld [0:1];
	assign fe_fld[0] = i_access_port_iface_mode_field_0;
	assign fe_fld[1] = i_access_port_iface_mode_field_1;
	assign up_fld = i_uplink_iface_mode_field[`EPMUX_MODE_MSB:`EPMUX_MODE_LSB];

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_det
			reg [15:0] cnt_reg;
			reg hit_reg;
			// Presence must hold steady before it counts, to ride out hot insertion
			always @(posedge i_mclk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					cnt_reg <= 16'h0000;
					hit_reg <= 1'b0;
				end else if (!pres_s2_reg[g]) begin
					cnt_reg <= 16'h0000;
					hit_reg <= 1'b0;
				end else if (cnt_reg == `EPMUX_DET_CYCLES) begin
					hit_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
			assign pres_w[g] = hit_reg;
			assign idle[g] = strap_s_reg[1] & ~hit_reg;
		end
		for (g = 0; g < 2; g = g + 1) begin : g_fe
			epmux_fe_port u_port (
				.i_mclk(i_mclk),
				.i_arst_n(i_arst_n),
				.i_access_port_iface_mode_field(fe_fld[g]),
				.i_idle(idle[g]),
				.i_rxd(i_fe_rxd[g*4+3:g*4]),
				.i_access_carrier_valid_in(i_fe_crs_dv[g]),
				.i_col(i_fe_col[g]),
				.i_access_tx_clock_pin(i_fe_txclk[g]),
				.i_access_rx_clock_pin(i_fe_rxclk[g]),
				.i_clk_drive(i_fe_clk_drive[g]),
				.i_txen(i_fe_txen[g]),
				.i_txd(i_fe_txd[g*4+3:g*4]),
				.o_mode(fe_mode_w[g*3+2:g*3]),
				.o_rxd(fe_rxd_w[g*4+3:g*4]),
				.o_rx_valid(fe_rxv_w[g]),
				.o_col(fe_col_w[g]),
				.o_tx_clk_edge(fe_edge_w[g]),
				.o_txen(fe_txen_w[g]),
				.o_txd(fe_txd_w[g*4+3:g*4]),
				.o_clk_oe(fe_oe_w[g])
			);
		end
	endgenerate

	always @* begin
		case (up_fld)
			`EPMUX_UP_GMII: up_mode_next = `EPMUX_FM_GMII;
			`EPMUX_UP_MII: up_mode_next = `EPMUX_FM_MII;
			default: up_mode_next = `EPMUX_FM_IDLE;
		endcase
		if (idle[2])
			up_mode_next = `EPMUX_FM_IDLE;
	end

	always @(*) begin
		o_fe_mode = fe_mode_w;
		o_fe_rxd = fe_rxd_w;
		o_fe_rx_valid = fe_rxv_w;
		o_fe_col = fe_col_w;
		o_fe_tx_clk_edge = fe_edge_w;
		o_fe_clk_oe = fe_oe_w;
		o_fe_txen = fe_txen_w;
		o_fe_txd = fe_txd_w;
		o_present = pres_w;
	end

	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pres_s1_reg <= 3'h0;
			pres_s2_reg <= 3'h0;
			strap_s_reg <= 2'h0;
			gref_s_reg <= 2'h0;
			mtx_s_reg <= 2'h0;
			gref_d_reg <= 1'b0;
			mtx_d_reg <= 1'b0;
			o_up_mode <= `EPMUX_FM_IDLE;
			o_up_rxd <= 8'h00;
			o_up_rxdv <= 1'b0;
			o_up_rxer <= 1'b0;
			o_up_crs <= 1'b0;
			o_up_col <= 1'b0;
			o_up_tx_clk_edge <= 1'b0;
			o_uplink_gigabit_tx_clock_out <= 1'b0;
			o_up_txen <= 1'b0;
			o_up_txd <= 8'h00;
		end else begin
			pres_s1_reg <= i_module_present;
			pres_s2_reg <= pres_s1_reg;
			strap_s_reg <= {strap_s_reg[0], i_module_detect_strap};
			gref_s_reg <= {gref_s_reg[0], i_gigabit_reference_clock_in};
			mtx_s_reg <= {mtx_s_reg[0], i_uplink_mii_tx_clock_in};
			gref_d_reg <= gref_s_reg[1];
			mtx_d_reg <= mtx_s_reg[1];
			o_up_mode <= up_mode_next;
			o_up_rxd <= 8'h00;
			o_up_rxdv <= 1'b0;
			o_up_rxer <= 1'b0;
			o_up_crs <= 1'b0;
			o_up_col <= 1'b0;
			o_up_tx_clk_edge <= 1'b0;
			o_uplink_gigabit_tx_clock_out <= 1'b0;
			o_up_txen <= 1'b0;
			o_up_txd <= 8'h00;
			case (o_up_mode)
				`EPMUX_FM_GMII: begin
					o_up_rxd <= i_up_rxd;
					o_up_rxdv <= i_up_rxdv;
					o_up_rxer <= i_up_rxer;
					o_up_crs <= i_up_crs;
					o_up_col <= i_up_col;
					o_up_txen <= i_up_txen;
					o_up_txd <= i_up_txd;
					// Sampled copy of the reference; true gigabit rate needs a PLL
					o_uplink_gigabit_tx_clock_out <= gref_s_reg[1];
					o_up_tx_clk_edge <= gref_s_reg[1] & ~gref_d_reg;
				end
				`EPMUX_FM_MII: begin
					o_up_rxd <= {4'h0, i_up_rxd[3:0]};
					o_up_rxdv <= i_up_rxdv;
					o_up_crs <= i_up_crs;
					o_up_col <= i_up_col;
					o_up_txen <= i_up_txen;
					o_up_txd <= {4'h0, i_up_txd[3:0]};
					o_up_tx_clk_edge <= mtx_s_reg[1] & ~mtx_d_reg;
				end
				default: begin
				end
			endcase
		end
	end
endmodule

/* File: tb/epmux_sva.sv */
// Checker for the pin-mode mapping block
`timescale 1ns/100ps
module epmux_sva (
	input wire i_mclk,
	input wire i_arst_n,
	input wire i_module_detect_strap,
	input wire [7:0] i_access_port_iface_mode_field_0,
	input wire [7:0] i_uplink_iface_mode_field,
	input wire [7:0] i_fe_rxd,
	input wire [7:0] i_up_rxd,
	input wire [5:0] o_fe_mode,
	input wire [7:0] o_fe_rxd,
	input wire [2:0] o_up_mode,
	input wire [7:0] o_up_rxd
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	a_fe_rmii_map: assert property (
		o_fe_mode[2:0] == 3'h1 |=>
		o_fe_rxd[3:0] == {2'h0, $past(i_fe_rxd[1:0])}) else $error("rmii");
	a_fe_mii_map: assert property (
		o_fe_mode[2:0] == 3'h2 |=>
		o_fe_rxd[3:0] == $past(i_fe_rxd[3:0])) else $error("mii");
	a_fe_gpsi_map: assert property (
		o_fe_mode[2:0] == 3'h3 |=>
		o_fe_rxd[3:0] == {3'h0, $past(i_fe_rxd[0])}) else $error("gpsi");
	a_fe_mode_decode: assert property (
		(!i_module_detect_strap [*3] ##0
		i_access_port_iface_mode_field_0[4:3] == 2'h3) |=>
		o_fe_mode[2:0] == 3'h1) else $error("fe decode");
	a_fe_code_reserved: assert property (
		i_access_port_iface_mode_field_0[4:3] == 2'h2 |=>
		o_fe_mode[2:0] == 3'h0) else $error("fe reserved");
	a_up_gmii_map: assert property (
		o_up_mode == 3'h4 |=> o_up_rxd == $past(i_up_rxd)) else $error("gmii");
	a_up_mii_map: assert property (
		o_up_mode == 3'h2 |=>
		o_up_rxd == {4'h0, $past(i_up_rxd[3:0])}) else $error("up mii");
	a_up_code_reserved: assert property (
		i_uplink_iface_mode_field[4:3] == 2'h1 |=>
		o_up_mode == 3'h0) else $error("up reserved");
endmodule
bind epmux_top epmux_sva u_sva (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
	.i_module_detect_strap(i_module_detect_strap),
	.i_access_port_iface_mode_field_0(i_access_port_iface_mode_field_0),
	.i_uplink_iface_mode_field(i_uplink_iface_mode_field),
	.i_fe_rxd(i_fe_rxd), .i_up_rxd(i_up_rxd), .o_fe_mode(o_fe_mode),
	.o_fe_rxd(o_fe_rxd), .o_up_mode(o_up_mode), .o_up_rxd(o_up_rxd));

/* File: tb/epmux_phy_model.sv */
// Far-side PHY model: receive pins and link clock
`timescale 1ns/100ps
module epmux_phy_model (
	input wire i_run,
	input wire [7:0] i_pat,
	output reg o_clk,
	output wire [7:0] o_rxd,
	output wire o_dv
);
	// Clock stands still outside frames; phase offset avoids edge races
	initial begin
		o_clk = 1'b0;
		#3;
		forever #80 o_clk = i_run ? ~o_clk : 1'b0;
	end
	// Released lines show the inverse so stale data cannot pass
	assign o_rxd = i_run ? i_pat : ~i_pat;
	assign o_dv = i_run;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the pin-mode mapping block
`timescale 1ns/100ps
module testbench;
	reg i_mclk = 1'b0;
	reg i_arst_n = 1'b0;
	reg strap = 1'b0;
	reg run = 1'b0;
	reg [2:0] pres = 3'h0;
	reg [1:0] drv = 2'h1;
	reg [7:0] mf0 = 8'h00;
	reg [7:0] mf1 = 8'h00;
	reg [7:0] mfu = 8'h00;
	reg [7:0] pat = 8'h6B;
	reg [7:0] txd = 8'hD7;
	integer err_count = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	integer k;
	integer n0, n1, n2, n3;
	wire pclk;
	wire pdv;
	wire [1:0] fval, fcol, fedge, foe, ften;
	wire urxdv, urxer, ucrs, ucol, uedge, ugclk, uten;
	wire [7:0] prxd, frxd, ftxd, urxd, utxd;
	wire [5:0] fm;
	wire [2:0] um, prs;
	epmux_phy_model phy (.i_run(run), .i_pat(pat), .o_clk(pclk),
		.o_rxd(prxd), .o_dv(pdv));
	epmux_top uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_module_detect_strap(strap), .i_module_present(pres),
		.i_access_port_iface_mode_field_0(mf0),
		.i_access_port_iface_mode_field_1(mf1),
		.i_uplink_iface_mode_field(mfu), .i_fe_rxd(prxd),
		.i_fe_crs_dv({2{pdv}}), .i_fe_col({2{pdv}}), .i_fe_txclk({2{pclk}}),
		.i_fe_rxclk({2{pclk}}), .i_fe_clk_drive(drv), .i_fe_txen({2{run}}),
		.i_fe_txd(txd), .i_up_rxd(prxd), .i_up_rxdv(pdv), .i_up_rxer(pdv),
		.i_up_crs(pdv), .i_up_col(pdv), .i_gigabit_reference_clock_in(pclk),
		.i_uplink_mii_tx_clock_in(pclk), .i_up_txen(run), .i_up_txd(txd),
		.o_fe_mode(fm), .o_fe_rxd(frxd), .o_fe_rx_valid(fval),
		.o_fe_col(fcol), .o_fe_tx_clk_edge(fedge), .o_fe_clk_oe(foe),
		.o_fe_txen(ften), .o_fe_txd(ftxd), .o_up_mode(um), .o_up_rxd(urxd),
		.o_up_rxdv(urxdv), .o_up_rxer(urxer), .o_up_crs(ucrs),
		.o_up_col(ucol), .o_up_tx_clk_edge(uedge),
		.o_uplink_gigabit_tx_clock_out(ugclk), .o_up_txen(uten),
		.o_up_txd(utxd), .o_present(prs));
	always #10 i_mclk = ~i_mclk;
	task end_sim;
	begin
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (cyc == 1000) begin
			err_count = err_count + 1;
			end_sim;
		end
	end
	task chk(input [63:0] nm, input [7:0] got, input [7:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("BAD %0s exp %h got %h", nm, exp, got);
		end
	end
	endtask
	function [6:0] fx(input [1:0] c);
		case (c)
			2'h3: fx = {3'h1, 4'h3};
			2'h1: fx = {3'h2, 4'hF};
			2'h0: fx = {3'h3, 4'h1};
			default: fx = 7'h00;
		endcase
	endfunction
	task settle;
	begin
		repeat (5) @(posedge i_mclk);
		#1;
	end
	endtask
	// Window spans four whole link periods of 8 cycles each
	task count_edges;
	begin
		n0 = 0;
		n1 = 0;
		n2 = 0;
		n3 = 0;
		repeat (32) begin
			@(posedge i_mclk);
			#1;
			n0 = n0 + fedge[0];
			n1 = n1 + fedge[1];
			n2 = n2 + uedge;
			n3 = n3 + ugclk;
		end
	end
	endtask
	// Only bits 4:3 may matter, so the other field bits carry nonzero patterns
	task t_fe;
		reg [6:0] e0, e1;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			@(posedge i_mclk);
			run <= 1'b1;
			mf0 <= {3'h5, k[1:0], 3'h6};
			mf1 <= {3'h2, ~k[1:0], 3'h1};
			drv <= k[1:0];
			settle;
			e0 = fx(k[1:0]);
			e1 = fx(~k[1:0]);
			chk("femode", {2'h0, fm}, {2'h0, e1[6:4], e0[6:4]});
			chk("ferxd", frxd, pat & {e1[3:0], e0[3:0]});
			chk("fetxd", ftxd, txd & {e1[3:0], e0[3:0]});
			chk("fevalid", {6'h0, fval}, {6'h0, |e1[6:4], |e0[6:4]});
			chk("fetxen", {6'h0, ften}, {6'h0, |e1[6:4], |e0[6:4]});
			chk("fecol", {6'h0, fcol}, {6'h0, e1[5], e0[5]});
			chk("feclkoe", {6'h0, foe}, {6'h0, k[1:0] & {e1[5], e0[5]}});
			count_edges;
			chk("feedge0", n0[7:0], e0[5] ? 8'h04 : 8'h00);
			chk("feedge1", n1[7:0], e1[5] ? 8'h04 : 8'h00);
		end
		$display("access done");
	end
	endtask
	task t_up;
		reg [10:0] e;
		reg v;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			@(posedge i_mclk);
			mfu <= {3'h4, k[1:0], 3'h3};
			settle;
			e = (k == 3) ? 11'h4FF : (k == 0) ? 11'h20F : 11'h000;
			v = |e[10:8];
			chk("upmode", {5'h0, um}, {5'h0, e[10:8]});
			chk("uprxd", urxd, pat & e[7:0]);
			chk("uptxd", utxd, txd & e[7:0]);
			chk("uprxc", {5'h0, urxdv, urxer, ucrs}, {5'h0, v, e[10], v});
			chk("upcoltx", {6'h0, ucol, uten}, {6'h0, v, v});
			count_edges;
			chk("upedge", n2[7:0], v ? 8'h04 : 8'h00);
			chk("upgclk", n3[7:0], e[10] ? 8'h10 : 8'h00);
		end
		$display("uplink done");
	end
	endtask
	task t_det;
	begin
		@(posedge i_mclk);
		mf0 <= 8'h18;
		mfu <= 8'h18;
		strap <= 1'b1;
		settle;
		chk("nomodfe", {2'h0, fm}, 8'h00);
		chk("nomodup", {5'h0, um}, 8'h00);
		chk("nomodrx", frxd | urxd, 8'h00);
		chk("nomodtx", ftxd, 8'h00);
		chk("nomodvl", {4'h0, fval, fcol}, 8'h00);
		chk("nomodcc", {5'h0, urxdv, ucrs, ucol}, 8'h00);
		@(posedge i_mclk);
		pres <= 3'h7;
		repeat (5) settle;
		chk("present", {5'h0, prs}, 8'h07);
		chk("hotfe", {2'h0, fm}, 8'h19);
		chk("hotup", {5'h0, um}, 8'h04);
		@(posedge i_mclk);
		pres <= 3'h0;
		repeat (2) settle;
		chk("removed", {5'h0, prs}, 8'h00);
		$display("detect done");
	end
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
		t_fe;
		t_up;
		t_det;
		end_sim;
	end
endmodule
